// File: design/sfie_pkg.sv
// package: constants and types for the status-flag instruction executor
package sfie_pkg;

    // =========================================================
    // status register bit positions
    localparam int unsigned STAT_C = 0;
    localparam int unsigned STAT_Z = 1;
    localparam int unsigned STAT_N = 2;
    localparam int unsigned STAT_V = 3;
    localparam int unsigned STAT_S = 4;
    localparam int unsigned STAT_H = 5;
    localparam int unsigned STAT_T = 6;
    localparam int unsigned STAT_I = 7;
    localparam logic [7:0]  STAT_RESET = 8'h00;

    // =========================================================
    // cycle counts
    localparam int unsigned FLAG_OP_CYCLES     = 1;
    localparam int unsigned IDLE_OP_CYCLES     = 1;
    localparam int unsigned WATCHDOG_OP_CYCLES = 1;
    localparam int unsigned SLEEP_OP_CYCLES    = 3;

    // =========================================================
    // operation codes presented by the decode path
    typedef enum logic [3:0] {
        idle_op,
        sign_flag_set_op,
        sign_flag_clear_op,
        overflow_set_op,
        overflow_clear_op,
        half_carry_set_op,
        half_carry_clear_op,
        irq_enable_op,
        irq_disable_op,
        negative_clear_op,
        zero_set_op,
        zero_clear_op,
        transfer_bit_set_op,
        transfer_bit_clear_op,
        sleep_op,
        watchdog_restart_op
    } sfie_op_t;

    // =========================================================
    // sequencer states
    typedef enum logic [1:0] {
        ST_READY,
        ST_SLEEP1,
        ST_SLEEP2
    } sfie_st_t;

endpackage

// File: design/sfie_op_decode.sv
// module: maps an operation code onto a status-bit write
`timescale 1ns/1ns
module sfie_op_decode (
    input  wire sfie_pkg::sfie_op_t opCode,
    output logic                    flagWe,
    output logic [2:0]              flagIdx,
    output logic                    flagVal
);
    import sfie_pkg::*;

    // =========================================================
    // decode: {write, index, value}
    function automatic logic [4:0] decodeOp(input sfie_op_t op);
        case (op)
            sign_flag_set_op:      decodeOp = {1'b1, 3'(STAT_S), 1'b1};
            sign_flag_clear_op:    decodeOp = {1'b1, 3'(STAT_S), 1'b0};
            overflow_set_op:       decodeOp = {1'b1, 3'(STAT_V), 1'b1};
            overflow_clear_op:     decodeOp = {1'b1, 3'(STAT_V), 1'b0};
            half_carry_set_op:     decodeOp = {1'b1, 3'(STAT_H), 1'b1};
            half_carry_clear_op:   decodeOp = {1'b1, 3'(STAT_H), 1'b0};
            irq_enable_op:         decodeOp = {1'b1, 3'(STAT_I), 1'b1};
            irq_disable_op:        decodeOp = {1'b1, 3'(STAT_I), 1'b0};
            negative_clear_op:     decodeOp = {1'b1, 3'(STAT_N), 1'b0};
            zero_set_op:           decodeOp = {1'b1, 3'(STAT_Z), 1'b1};
            zero_clear_op:         decodeOp = {1'b1, 3'(STAT_Z), 1'b0};
            transfer_bit_set_op:   decodeOp = {1'b1, 3'(STAT_T), 1'b1};
            transfer_bit_clear_op: decodeOp = {1'b1, 3'(STAT_T), 1'b0};
            // idle, sleep and watchdog restart touch no flag
            default:               decodeOp = 5'h00;
        endcase
    endfunction

    always_comb begin
        {flagWe, flagIdx, flagVal} = decodeOp(opCode);
    end

endmodule // sfie_op_decode

// File: design/sfie_exec.sv
// module: executes the single-operand status-flag, idle, sleep and watchdog ops
// =========================================================
// Contract
// - sign-test set op sets S in one cycle, other bits kept.
// - sign-test clear op clears S in one cycle, other bits kept.
// - overflow set op sets V in one cycle, other flags kept.
// - overflow clear op clears V in one cycle, other flags kept.
// - half-carry set op sets H in one cycle, other flags kept.
// - half-carry clear op clears H in one cycle, other flags kept.
// - irq enable sets I, irq disable clears I, one cycle each.
// - sleep takes three cycles, no flag change, then hands over to sleep logic.
// - watchdog restart takes one cycle, no flag change, pulses restart.
`timescale 1ns/1ns
module sfie_exec (
    input  wire  logic               core_clk,
    input  wire  logic               nrst,
    input  wire  logic               opValid,
    input  wire  sfie_pkg::sfie_op_t opCode,
    output logic                     opReady,
    output logic                     opDone,
    output logic [7:0]               statusReg,
    output logic                     sleepEnter,
    output logic                     wdRestart
);
    import sfie_pkg::*;

    // =========================================================
    // state
    typedef struct packed {
        sfie_st_t   st;
        logic [7:0] status;
        logic       ready;
        logic       done;
        logic       sleepGo;
        logic       wdGo;
    } sfie_state_t;

    sfie_state_t cur_r;
    sfie_state_t cur_nxt;
    logic        flagWe;
    logic [2:0]  flagIdx;
    logic        flagVal;
    logic        taken;

    sfie_op_decode i_sfie_op_decode (
        .opCode  (opCode),
        .flagWe  (flagWe),
        .flagIdx (flagIdx),
        .flagVal (flagVal)
    );

    // ready comes from a flop, so the decode path sees no comb loop
    assign taken = opValid && cur_r.ready;

    // =========================================================
    // next state
    always_comb begin
        cur_nxt         = cur_r;
        cur_nxt.done    = 1'b0;
        cur_nxt.sleepGo = 1'b0;
        cur_nxt.wdGo    = 1'b0;
        case (cur_r.st)
            ST_READY: begin
                if (taken) begin
                    if (flagWe) begin
                        cur_nxt.status[flagIdx] = flagVal;
                    end
                    if (opCode == sleep_op) begin
                        cur_nxt.st    = ST_SLEEP1;
                        cur_nxt.ready = 1'b0;
                    end else begin
                        // single-cycle ops, idle included, finish at once
                        cur_nxt.done = 1'b1;
                    end
                    if (opCode == watchdog_restart_op) begin
                        cur_nxt.wdGo = 1'b1;
                    end
                end
            end
            ST_SLEEP1: begin
                cur_nxt.st = ST_SLEEP2;
            end
            ST_SLEEP2: begin
                // third cycle ends: hand over to the sleep controller
                cur_nxt.st      = ST_READY;
                cur_nxt.ready   = 1'b1;
                cur_nxt.done    = 1'b1;
                cur_nxt.sleepGo = 1'b1;
            end
            default: begin
                cur_nxt.st    = ST_READY;
                cur_nxt.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cur_r.st      <= ST_READY;
            cur_r.status  <= STAT_RESET;
            cur_r.ready   <= 1'b1;
            cur_r.done    <= 1'b0;
            cur_r.sleepGo <= 1'b0;
            cur_r.wdGo    <= 1'b0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign opReady    = cur_r.ready;
    assign opDone     = cur_r.done;
    assign statusReg  = cur_r.status;
    assign sleepEnter = cur_r.sleepGo;
    assign wdRestart  = cur_r.wdGo;

    // =========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_sign_set;
        taken && opCode == sign_flag_set_op |=>
            statusReg[STAT_S] && opDone &&
            (statusReg & 8'hEF) == ($past(statusReg) & 8'hEF);
    endproperty
    a_sign_set: assert property (p_sign_set)
        else $error("sign set wrong");

    property p_sign_clear;
        taken && opCode == sign_flag_clear_op |=>
            !statusReg[STAT_S] && (statusReg & 8'hEF) == ($past(statusReg) & 8'hEF);
    endproperty
    a_sign_clear: assert property (p_sign_clear)
        else $error("sign clear wrong");

    property p_ovf_set;
        taken && opCode == overflow_set_op |=>
            statusReg[STAT_V] && (statusReg & 8'hF7) == ($past(statusReg) & 8'hF7);
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow set wrong");

    property p_ovf_clear;
        taken && opCode == overflow_clear_op |=>
            !statusReg[STAT_V] && (statusReg & 8'hF7) == ($past(statusReg) & 8'hF7);
    endproperty
    a_ovf_clear: assert property (p_ovf_clear)
        else $error("overflow clear wrong");

    property p_half_set;
        taken && opCode == half_carry_set_op |=>
            statusReg[STAT_H] && (statusReg & 8'hDF) == ($past(statusReg) & 8'hDF);
    endproperty
    a_half_set: assert property (p_half_set)
        else $error("half carry set wrong");

    property p_half_clear;
        taken && opCode == half_carry_clear_op |=>
            !statusReg[STAT_H] && (statusReg & 8'hDF) == ($past(statusReg) & 8'hDF);
    endproperty
    a_half_clear: assert property (p_half_clear)
        else $error("half carry clear wrong");

    property p_irq;
        taken && (opCode == irq_enable_op || opCode == irq_disable_op) |=>
            statusReg[STAT_I] == $past(opCode == irq_enable_op) && opDone &&
            statusReg[6:0] == $past(statusReg[6:0]);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt enable bit wrong");

    property p_sleep;
        taken && opCode == sleep_op |=>
            (!opReady && !sleepEnter && $stable(statusReg)) [*2] ##1
            (sleepEnter && opReady && opDone && $stable(statusReg));
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep sequence wrong");

    // no hand-over pulse without a sleep taken three cycles before
    property p_sleep_cause;
        sleepEnter |-> $past(taken && opCode == sleep_op, 3);
    endproperty
    a_sleep_cause: assert property (p_sleep_cause)
        else $error("stray sleep hand-over");

    property p_wdr;
        taken && opCode == watchdog_restart_op |=>
            wdRestart && opDone && opReady && $stable(statusReg) ##1
            (wdRestart == $past(taken && opCode == watchdog_restart_op));
    endproperty
    a_wdr: assert property (p_wdr)
        else $error("watchdog restart wrong");

    property p_wd_cause;
        wdRestart |-> $past(taken && opCode == watchdog_restart_op);
    endproperty
    a_wd_cause: assert property (p_wd_cause)
        else $error("stray watchdog restart");

    property p_zero;
        taken && (opCode == zero_set_op || opCode == zero_clear_op) |=>
            statusReg[STAT_Z] == $past(opCode == zero_set_op) &&
            (statusReg & 8'hFD) == ($past(statusReg) & 8'hFD);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");

    property p_neg_t;
        taken && (opCode == negative_clear_op || opCode == transfer_bit_clear_op) |=>
            statusReg == ($past(statusReg) &
                ($past(opCode == negative_clear_op) ? 8'hFB : 8'hBF));
    endproperty
    a_neg_t: assert property (p_neg_t)
        else $error("negative or transfer clear wrong");

    property p_tbit_set;
        taken && opCode == transfer_bit_set_op |=>
            statusReg == ($past(statusReg) | 8'h40) && opDone;
    endproperty
    a_tbit_set: assert property (p_tbit_set)
        else $error("transfer bit set wrong");

    property p_idle;
        taken && opCode == idle_op |=>
            $stable(statusReg) && opDone && opReady && !sleepEnter && !wdRestart;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle op changed state");

    c_sleep: cover property (taken && opCode == sleep_op ##3 sleepEnter);
    c_wdr:   cover property (taken && opCode == watchdog_restart_op ##1 wdRestart);
    c_b2b:   cover property (taken && opCode == irq_enable_op ##1 taken);
    c_vset:  cover property (taken && opCode == overflow_set_op ##1 statusReg[STAT_V]);

endmodule // sfie_exec

// File: testbench/sfie_exec_tb.sv
// testbench: directed and random ops against a reference model of the executor
`timescale 1ns/1ns
module sfie_exec_tb;
    import sfie_pkg::*;

    // =========================================================
    // design signals
    // clock and reset preset here so time zero shows no false edge
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        opValid;
    sfie_op_t    opCode;
    logic        opReady;
    logic        opDone;
    logic [7:0]  statusReg;
    logic        sleepEnter;
    logic        wdRestart;

    // =========================================================
    // reference model state, preset so the first negedge compares sanely
    logic [7:0]  expStat_r  = STAT_RESET;
    logic        expReady_r = 1'b1;
    logic        expDone_r  = 1'b0;
    logic        expSlp_r   = 1'b0;
    logic        expWd_r    = 1'b0;
    logic [1:0]  slpCnt_r   = 2'h0;
    logic [31:0] lfsr;
    int          nFail;
    int          numChecks;

    sfie_exec i_sfie_exec (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .opValid    (opValid),
        .opCode     (opCode),
        .opReady    (opReady),
        .opDone     (opDone),
        .statusReg  (statusReg),
        .sleepEnter (sleepEnter),
        .wdRestart  (wdRestart)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // =========================================================
    // helpers
    function automatic logic [31:0] lfsrNext(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [7:0] nextStat(input logic [7:0] s, input sfie_op_t op);
        logic [7:0] r;
        r = s;
        case (op)
            sign_flag_set_op:      r[STAT_S] = 1'b1;
            sign_flag_clear_op:    r[STAT_S] = 1'b0;
            overflow_set_op:       r[STAT_V] = 1'b1;
            overflow_clear_op:     r[STAT_V] = 1'b0;
            half_carry_set_op:     r[STAT_H] = 1'b1;
            half_carry_clear_op:   r[STAT_H] = 1'b0;
            irq_enable_op:         r[STAT_I] = 1'b1;
            irq_disable_op:        r[STAT_I] = 1'b0;
            negative_clear_op:     r[STAT_N] = 1'b0;
            zero_set_op:           r[STAT_Z] = 1'b1;
            zero_clear_op:         r[STAT_Z] = 1'b0;
            transfer_bit_set_op:   r[STAT_T] = 1'b1;
            transfer_bit_clear_op: r[STAT_T] = 1'b0;
            default:               r = s;
        endcase
        return r;
    endfunction

    // =========================================================
    // reference model; requests during a sleep are dropped silently
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            expStat_r  <= STAT_RESET;
            expReady_r <= 1'b1;
            expDone_r  <= 1'b0;
            expSlp_r   <= 1'b0;
            expWd_r    <= 1'b0;
            slpCnt_r   <= 2'h0;
        end else begin
            expDone_r <= 1'b0;
            expSlp_r  <= 1'b0;
            expWd_r   <= 1'b0;
            if (slpCnt_r != 2'h0) begin
                slpCnt_r <= slpCnt_r - 2'h1;
                if (slpCnt_r == 2'h1) begin
                    expReady_r <= 1'b1;
                    expDone_r  <= 1'b1;
                    expSlp_r   <= 1'b1;
                end
            end else if (opValid === 1'b1) begin
                expDone_r <= (opCode != sleep_op);
                expWd_r   <= (opCode == watchdog_restart_op);
                if (opCode == sleep_op) begin
                    slpCnt_r   <= 2'h2;
                    expReady_r <= 1'b0;
                end
                expStat_r <= nextStat(expStat_r, opCode);
            end
        end
    end

    // =========================================================
    // comparisons, every cycle where outputs have settled
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
        numChecks++;
        if (s !== e) begin
            nFail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    always @(negedge core_clk) begin
        check("statusReg", expStat_r, statusReg);
        check("opDone", {7'h00, expDone_r}, {7'h00, opDone});
        check("opReady", {7'h00, expReady_r}, {7'h00, opReady});
        check("sleepEnter", {7'h00, expSlp_r}, {7'h00, sleepEnter});
        check("wdRestart", {7'h00, expWd_r}, {7'h00, wdRestart});
    end

    // =========================================================
    // stimulus
    task automatic drive(input logic v, input sfie_op_t c);
        opValid <= v;
        opCode  <= c;
        @(posedge core_clk);
    endtask

    task automatic testDone;
        if (nFail == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        nFail      = 0;
        numChecks  = 0;
        lfsr       = 32'h1796;
        nrst       = 1'b0;
        opValid    = 1'b0;
        opCode     = idle_op;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        // every code back to back, then in reverse so sets follow clears
        for (int k = 0; k < 16; k++) drive(1'b1, sfie_op_t'(k[3:0]));
        for (int k = 15; k >= 0; k--) drive(1'b1, sfie_op_t'(k[3:0]));
        drive(1'b0, sleep_op);
        // sleeps held valid: the ones landing in a busy sleep are refused
        repeat (5) drive(1'b1, sleep_op);
        drive(1'b1, sign_flag_set_op);
        // two restarts back to back: the second pulse must follow the first
        repeat (2) drive(1'b1, watchdog_restart_op);
        for (int i = 0; i < 3000; i++) begin
            lfsr = lfsrNext(lfsr);
            // short reset in mid-run, asserted on a rising edge along with an op
            nrst <= !(i == 1500 || i == 1501);
            drive(lfsr[0] | lfsr[1], sfie_op_t'(lfsr[7:4]));
        end
        drive(1'b0, idle_op);
        repeat (4) @(posedge core_clk);
        testDone();
    end

endmodule // sfie_exec_tb
